//--- src/tmon_cfg.svh
// Operation
// - Each sequence converts local and remote channel; both results readable afterwards.
// - Status busy flag is set during a sequence, cleared at its end.
// - Temperature registers hold last completed results until the next completion.
// - Configuration bit 6 set selects standby; clear selects autonomous conversion.
// - Standby keeps all register values and the serial interface fully active.
// - One-shot converts even in standby; device returns to standby afterwards.
// - Command byte 0Fh is the one-shot command; send byte starts conversion.
// - Standby during a conversion aborts it; stored temperatures stay unchanged.
// - Only write byte, read byte, send byte and receive byte transfers exist.
// - Receive byte returns register at pointer from last command byte.
// - Local at 00h, remote at 01h, one degree per count, MSB first.
// - Extended registers 10h remote, 11h local add three fraction bits.
// - Fraction sits in top three bits; lower five bits read zero.
// - Main and extended registers of a channel update in the same cycle.
// - Write byte: address, command, data; each byte acknowledged, data stored.
// - Read byte: command, repeated start, read; host ends with not-acknowledge.
// - Send byte sets the pointer and acts on commands like one-shot.
// - Per-channel high and low limits; alert when temperature reaches high limit.
// - High limits reset 85/95, or 85/85 on the continuity variant; lows zero.
// - Overtemperature output asserts when either temperature reaches its limit.
// - Overtemperature limits reset 85/125, or 85/85 on the continuity variant.
// - Remote junction open or short loads remote temperature with all ones.
// - Open junction sets status bit 2; continuity variant also raises alert.
// - Status shows no fault after reset until the first conversion completes.
// - Serial interface resets when the clock line stays low past the timeout.
// - Alert latches; status read or alert response clears it once cause gone.
`ifndef TMON_CFG_SVH
`define TMON_CFG_SVH
`define TM_CLK_KHZ   100000
`define TM_CONV_MS   125
`define TM_RATE_MS   250
`define TM_TMO_MS    25
`define TM_DEV_ADDR  7'h4c
`define TM_ARA_ADDR  7'h0c
`define TM_REG_LT    8'h00
`define TM_REG_RT    8'h01
`define TM_REG_STAT  8'h02
`define TM_REG_CFG   8'h03
`define TM_REG_LHI   8'h05
`define TM_REG_LLO   8'h06
`define TM_REG_RHI   8'h07
`define TM_REG_RLO   8'h08
`define TM_REG_ONE   8'h0f
`define TM_REG_RTF   8'h10
`define TM_REG_LTF   8'h11
`define TM_REG_ROV   8'h19
`define TM_REG_LOV   8'h20
`define TM_RST_85    8'h55
`define TM_RST_95    8'h5f
`define TM_RST_125   8'h7d
`define TM_RST_ZERO  8'h00
`define TM_FAULT_T   8'hff
`define TM_CFG_MASK  7
`define TM_CFG_STBY  6
`define TM_ST_BUSY   7
`define TM_ST_OPEN   2
`define TM_BIT_LAST  3'h7
`endif

//--- src/tmon_pkg.sv
package tmon_pkg;
  // Front end samples: 8 integer bits over 3 fraction bits.
  typedef struct packed {
    logic [10:0] loc;
    logic [10:0] rem;
    logic        rem_short;
    logic        rem_open;
  } sample_t;

  // Limit compare results, same order as status bits 6..0.
  typedef struct packed {
    logic lhi;
    logic llo;
    logic rhi;
    logic rlo;
    logic open;
    logic rov;
    logic lov;
  } cond_t;

  typedef struct packed {
    logic       wr;
    logic       cmd;
    logic       done;
    logic       ara;
    logic [7:0] data;
  } link_ev_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_AACK = 3'b011,
    L_RX   = 3'b010,
    L_RACK = 3'b110,
    L_TX   = 3'b111,
    L_MACK = 3'b101
  } link_st_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_CONV = 2'b01,
    C_DONE = 2'b11
  } conv_st_t;
endpackage : tmon_pkg

//--- src/conv_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmon_cfg.svh"
module conv_seq
  import tmon_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `TM_CONV_MS * `TM_CLK_KHZ,
  parameter int unsigned RATE_CYCLES = `TM_RATE_MS * `TM_CLK_KHZ
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Control
  input  wire logic standby,
  input  wire logic stby_req,
  input  wire logic one_shot,
  // Status
  output logic      busy,
  output logic      done
);
  conv_st_t    st;
  logic [31:0] conv_cnt;
  logic [31:0] rate_cnt;
  logic        go_os;
  logic        go_auto;

  // ------------------------------------------------------------
  // Start decisions
  // ------------------------------------------------------------
  // one-shot start
  assign go_os   = one_shot && (st == C_IDLE);
  assign go_auto = !standby && (st == C_IDLE) && (rate_cnt == 32'h0);
  assign busy    = (st != C_IDLE);
  assign done    = (st == C_DONE);

  // ------------------------------------------------------------
  // Sequence state
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st       <= C_IDLE;
      conv_cnt <= 32'h0;
    end
    else
    begin
      unique case (st)
        C_IDLE:
        begin
          if (go_os || go_auto)
          begin
            st       <= C_CONV;
            conv_cnt <= 32'(CONV_CYCLES - 1);
          end
        end
        C_CONV:
        begin
          if (stby_req)
            st <= C_IDLE;
          else if (conv_cnt == 32'h0)
            st <= C_DONE;
          else
            conv_cnt <= conv_cnt - 32'h1;
        end
        C_DONE:
        begin
          st     <= C_IDLE;
        end
        default:
          st <= C_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Conversion rate timer
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rate_cnt <= 32'h0;
    else if (go_os || go_auto)
      rate_cnt <= 32'(RATE_CYCLES - 1);
    else if (standby)
      rate_cnt <= 32'h0;
    else if (rate_cnt != 32'h0)
      rate_cnt <= rate_cnt - 32'h1;
  end
endmodule : conv_seq
`default_nettype wire

//--- src/tmon_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmon_cfg.svh"
module tmon_core
  import tmon_pkg::*;
#(
  parameter bit          CONT_VARIANT   = 1'b0,
  parameter int unsigned CONV_CYCLES    = `TM_CONV_MS * `TM_CLK_KHZ,
  parameter int unsigned RATE_CYCLES    = `TM_RATE_MS * `TM_CLK_KHZ,
  parameter int unsigned TIMEOUT_CYCLES = `TM_TMO_MS * `TM_CLK_KHZ
)(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // Serial bus pins
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  // Front end samples
  input  wire logic [10:0] LOCAL_SAMPLE,
  input  wire logic [10:0] REMOTE_SAMPLE,
  input  wire logic        REMOTE_JUNCTION_SHORT,
  input  wire logic        REMOTE_JUNCTION_OPEN,
  // Alarm pins, open drain
  output logic             ALERT_OE,
  output logic             OVERTEMP_OUT_OE
);
  localparam logic [7:0] RHI_RST = CONT_VARIANT ? `TM_RST_85 : `TM_RST_95;
  localparam logic [7:0] ROV_RST = CONT_VARIANT ? `TM_RST_85 : `TM_RST_125;

  logic        scl_m, scl_s, scl_d;
  logic        sda_m, sda_s, sda_d;
  logic        scl_rise, scl_fall, bus_start, bus_stop;
  logic [31:0] tmo_cnt;
  logic        tmo;
  link_st_t    lst;
  logic [3:0]  bit_cnt;
  logic [7:0]  sh;
  logic        rnw;
  logic        ara_sel;
  logic        second;
  link_ev_t    ev;
  logic [7:0]  ptr;
  logic [7:0]  cfg;
  logic [7:0]  status;
  logic [7:0]  local_temperature, remote_temperature;
  logic [2:0]  local_frac, remote_frac;
  logic [7:0]  local_alert_high_limit, local_low_limit;
  logic [7:0]  remote_alert_high_limit, remote_low_limit;
  logic [7:0]  local_overtemp_limit, remote_overtemp_limit;
  cond_t       cond;
  cond_t       next_cond;
  logic [7:0]  next_rem;
  logic [2:0]  next_rem_frac;
  logic        alert;
  logic        busy, done;
  logic        one_shot, stby_req;
  logic        stat_rd, ara_ok;
  logic [7:0]  tx_byte;
  sample_t     smp;

  // ------------------------------------------------------------
  // Register read decode
  // ------------------------------------------------------------
  // pointer read
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      `TM_REG_LT:   reg_read = local_temperature;
      `TM_REG_RT:   reg_read = remote_temperature;
      `TM_REG_STAT: reg_read = status | {busy, 7'h0};
      `TM_REG_CFG:  reg_read = cfg;
      `TM_REG_LHI:  reg_read = local_alert_high_limit;
      `TM_REG_LLO:  reg_read = local_low_limit;
      `TM_REG_RHI:  reg_read = remote_alert_high_limit;
      `TM_REG_RLO:  reg_read = remote_low_limit;
      `TM_REG_RTF:  reg_read = {remote_frac, 5'h0};
      `TM_REG_LTF:  reg_read = {local_frac, 5'h0};
      `TM_REG_ROV:  reg_read = remote_overtemp_limit;
      `TM_REG_LOV:  reg_read = local_overtemp_limit;
      default:      reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ------------------------------------------------------------
  // Pin synchronisers and bus events
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_m <= SCL_IN;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;

  // ------------------------------------------------------------
  // Bus timeout
  // ------------------------------------------------------------
  // clock low timeout
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN || scl_s)
      tmo_cnt <= 32'h0;
    else if (!tmo)
      tmo_cnt <= tmo_cnt + 32'h1;
  end

  assign tmo = (tmo_cnt >= 32'(TIMEOUT_CYCLES));

  // ------------------------------------------------------------
  // Serial slave engine
  // ------------------------------------------------------------
  assign tx_byte = ara_sel ? {`TM_DEV_ADDR, 1'b0} : reg_read(ptr);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN || tmo)
    begin
      lst     <= L_IDLE;
      bit_cnt <= 4'h0;
      sh      <= 8'h00;
      rnw     <= 1'b0;
      ara_sel <= 1'b0;
      second  <= 1'b0;
    end
    else if (bus_start)
    begin
      lst     <= L_ADDR;
      bit_cnt <= 4'h0;
      second  <= 1'b0;
    end
    else if (bus_stop)
      lst <= L_IDLE;
    else
    begin
      unique case (lst)
        L_IDLE:
          lst <= L_IDLE;
        L_ADDR:
        begin
          if (scl_rise)
          begin
            sh      <= {sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt[3])
          begin
            rnw     <= sh[0];
            ara_sel <= (sh[7:1] == `TM_ARA_ADDR);
            if (sh[7:1] == `TM_DEV_ADDR)
              lst <= L_AACK;
            else if (sh[7:1] == `TM_ARA_ADDR && sh[0] && alert)
              lst <= L_AACK;
            else
              lst <= L_IDLE;
          end
        end
        L_AACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (rnw)
            begin
              sh  <= tx_byte;
              lst <= L_TX;
            end
            else
              lst <= L_RX;
          end
        end
        L_RX:
        begin
          if (scl_rise)
          begin
            sh      <= {sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt[3])
            lst <= L_RACK;
        end
        L_RACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            second  <= 1'b1;
            lst     <= L_RX;
          end
        end
        L_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt[2:0] == `TM_BIT_LAST)
              lst <= L_MACK;
            else
            begin
              sh      <= {sh[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        L_MACK:
        begin
          if (scl_rise && sda_s)
            lst <= L_IDLE;
          else if (scl_fall)
          begin
            sh      <= tx_byte;
            bit_cnt <= 4'h0;
            lst     <= L_TX;
          end
        end
        default:
          lst <= L_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Engine events
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      ev <= '0;
    else
    begin
      ev.wr   <= (lst == L_RX) && scl_fall && bit_cnt[3] && !bus_start && !bus_stop;
      ev.cmd  <= !second;
      ev.data <= sh;
      ev.done <= (lst == L_MACK) && scl_rise && sda_s && !bus_start && !bus_stop;
      ev.ara  <= ara_sel;
    end
  end

  // ------------------------------------------------------------
  // Data line drive
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      SDA_OUT <= 1'b0;
      SDA_OE  <= 1'b0;
    end
    else
    begin
      SDA_OUT <= 1'b0;
      SDA_OE  <= (lst == L_AACK) || (lst == L_RACK) || ((lst == L_TX) && !sh[7]);
    end
  end

  // ------------------------------------------------------------
  // Pointer, configuration and commands
  // ------------------------------------------------------------
  // one-shot command
  assign one_shot = ev.wr && ev.cmd && (ev.data == `TM_REG_ONE);
  assign stby_req = ev.wr && !ev.cmd && (ptr == `TM_REG_CFG)
                    && ev.data[`TM_CFG_STBY] && !cfg[`TM_CFG_STBY];
  assign stat_rd  = ev.done && !ev.ara && (ptr == `TM_REG_STAT);
  assign ara_ok   = ev.done && ev.ara;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      ptr <= `TM_REG_LT;
    else if (ev.wr && ev.cmd)
      ptr <= ev.data;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      cfg <= 8'h00;
    else if (ev.wr && !ev.cmd && ptr == `TM_REG_CFG)
      cfg <= ev.data;
  end

  // ------------------------------------------------------------
  // Limit registers
  // ------------------------------------------------------------
  // alert limit reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      local_alert_high_limit  <= `TM_RST_85;
      remote_alert_high_limit <= RHI_RST;
      local_low_limit         <= `TM_RST_ZERO;
      remote_low_limit        <= `TM_RST_ZERO;
      local_overtemp_limit    <= `TM_RST_85;
      remote_overtemp_limit   <= ROV_RST;
    end
    else if (ev.wr && !ev.cmd)
    begin
      unique case (ptr)
        `TM_REG_LHI: local_alert_high_limit  <= ev.data;
        `TM_REG_RHI: remote_alert_high_limit <= ev.data;
        `TM_REG_LLO: local_low_limit         <= ev.data;
        `TM_REG_RLO: remote_low_limit        <= ev.data;
        `TM_REG_LOV: local_overtemp_limit    <= ev.data;
        `TM_REG_ROV: remote_overtemp_limit   <= ev.data;
        default:     local_low_limit         <= local_low_limit;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  // standby keeps bus alive
  conv_seq #(
    .CONV_CYCLES (CONV_CYCLES),
    .RATE_CYCLES (RATE_CYCLES)
  ) u_seq (
    .clk      (CLK_SYS),
    .resetn   (RESETN),
    .standby  (cfg[`TM_CFG_STBY]),
    .stby_req (stby_req),
    .one_shot (one_shot),
    .busy     (busy),
    .done     (done)
  );

  // ------------------------------------------------------------
  // Results and limit compare
  // ------------------------------------------------------------
  // front end samples
  assign smp = {LOCAL_SAMPLE, REMOTE_SAMPLE, REMOTE_JUNCTION_SHORT, REMOTE_JUNCTION_OPEN};

  assign next_rem      = (smp.rem_short || smp.rem_open) ? `TM_FAULT_T : smp.rem[10:3];
  assign next_rem_frac = (smp.rem_short || smp.rem_open) ? 3'h0 : smp.rem[2:0];

  always_comb
  begin
    next_cond.lhi  = smp.loc[10:3] >= local_alert_high_limit;
    next_cond.llo  = smp.loc[10:3] < local_low_limit;
    next_cond.rhi  = next_rem >= remote_alert_high_limit;
    next_cond.rlo  = next_rem < remote_low_limit;
    next_cond.open = smp.rem_open;
    next_cond.rov  = next_rem >= remote_overtemp_limit;
    next_cond.lov  = smp.loc[10:3] >= local_overtemp_limit;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      local_temperature  <= 8'h00;
      remote_temperature <= 8'h00;
      local_frac         <= 3'h0;
      remote_frac        <= 3'h0;
      cond               <= '0;
    end
    else if (done)
    begin
      local_temperature  <= smp.loc[10:3];
      local_frac         <= smp.loc[2:0];
      remote_temperature <= next_rem;
      remote_frac        <= next_rem_frac;
      cond               <= next_cond;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  // clear after reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      status <= 8'h00;
    else
    begin
      status <= ((stat_rd && !busy) ? (status & {1'b0, cond}) : status)
                | (done ? {1'b0, next_cond} : 8'h00);
    end
  end

  // ------------------------------------------------------------
  // Alarm outputs
  // ------------------------------------------------------------
  // alert latch
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      alert <= 1'b0;
    else if (done && !cfg[`TM_CFG_MASK] && (next_cond.lhi || next_cond.llo
             || next_cond.rhi || next_cond.rlo || (CONT_VARIANT && next_cond.open)))
      alert <= 1'b1;
    else if ((stat_rd || ara_ok) && !(cond.lhi || cond.llo || cond.rhi
             || cond.rlo || (CONT_VARIANT && cond.open)))
      alert <= 1'b0;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      ALERT_OE        <= 1'b0;
      OVERTEMP_OUT_OE <= 1'b0;
    end
    else
    begin
      ALERT_OE        <= alert;
      OVERTEMP_OUT_OE <= cond.rov || cond.lov;
    end
  end

endmodule : tmon_core
`default_nettype wire

//--- dv/tmon_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tmon_core_asserts
#(
  parameter int unsigned TIMEOUT_CYCLES = 300
)(
  // Clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RESETN,
  // Bus and alarm pins
  input  wire logic SCL_IN,
  input  wire logic SDA_OUT,
  input  wire logic SDA_OE,
  input  wire logic ALERT_OE,
  input  wire logic OVERTEMP_OUT_OE
);
  int unsigned low_cnt;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  // Counts how long the bus clock has stayed low.
  always_ff @(posedge CLK_SYS)
  begin
    if (SCL_IN || !RESETN)
      low_cnt <= 32'h0;
    else if (low_cnt <= TIMEOUT_CYCLES + 32'h8)
      low_cnt <= low_cnt + 32'h1;
  end

  sequence s_after_scl_fall;
    !SCL_IN && $past(SCL_IN, 9);
  endsequence

  sequence s_bit_held;
    SDA_OE [*8];
  endsequence

  a_reset_quiet: assert property (disable iff (1'b0)
    !RESETN |=> !SDA_OE && !ALERT_OE && !OVERTEMP_OUT_OE)
    else $error("outputs active after reset");
  a_sda_open_drain: assert property (!SDA_OUT)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data changed while clock high");
  a_drive_after_fall: assert property ($rose(SDA_OE) |-> s_after_scl_fall)
    else $error("data driven without a clock fall");
  a_bit_stands: assert property ($rose(SDA_OE) |=> s_bit_held)
    else $error("driven bit too short");
  a_timeout_release: assert property (low_cnt > TIMEOUT_CYCLES + 32'h6 |-> !SDA_OE)
    else $error("data held past bus timeout");
  a_alert_latch: assert property ($rose(ALERT_OE) |=> ALERT_OE [*8])
    else $error("alert not latched");
  a_alert_clear_idle: assert property ($fell(ALERT_OE) |-> !SDA_OE)
    else $error("alert cleared while device drives");
  a_ovt_steady: assert property ($changed(OVERTEMP_OUT_OE) |=> $stable(OVERTEMP_OUT_OE) [*8])
    else $error("overtemp output toggling");
endmodule : tmon_core_asserts
`default_nettype wire

//--- dv/smb_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmon_cfg.svh"
module smb_host
(
  // Clock
  input  wire logic clk,
  // Bus pins
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic host_low;

  // The data wire has a pull-up and goes low while either side pulls it.
  assign sda = ~(host_low | sda_oe);

  initial
  begin
    scl      = 1'b1;
    host_low = 1'b0;
  end

  task automatic step(input logic c, input logic l);
    @(posedge clk);
    scl      <= c;
    host_low <= l;
    repeat (11) @(posedge clk);
  endtask : step

  task automatic bit_io(input logic b, output logic r);
    step(1'b0, host_low);
    step(1'b0, ~b);
    step(1'b1, ~b);
    r = sda;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_io

  task automatic start();
    step(1'b0, host_low);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : start

  task automatic stop();
    step(1'b0, host_low);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : stop

  task automatic write(input logic [7:0] cmd, input logic [7:0] d, input logic has_d,
                       output logic ok);
    logic [7:0] q;
    logic       a;
    logic       b;
    logic       c;
    start();
    byte_io({`TM_DEV_ADDR, 1'b0}, q, a);
    byte_io(cmd, q, b);
    c = 1'b1;
    if (has_d)
      byte_io(d, q, c);
    stop();
    ok = a & b & c;
  endtask : write

  task automatic read(input logic [6:0] adr, input logic [7:0] cmd, input logic has_cmd,
                      output logic [7:0] q, output logic ok);
    logic [7:0] t;
    logic       a;
    logic       b;
    logic       c;
    logic       d;
    a = 1'b1;
    b = 1'b1;
    start();
    if (has_cmd)
    begin
      byte_io({`TM_DEV_ADDR, 1'b0}, t, a);
      byte_io(cmd, t, b);
      start();
    end
    byte_io({adr, 1'b1}, t, c);
    byte_io(8'hff, q, d);
    stop();
    ok = a & b & c;
  endtask : read

  // Holds the clock low in the acknowledge slot of an address byte.
  task automatic hang(input int n);
    logic [7:0] q;
    logic [7:0] a;
    a = {`TM_DEV_ADDR, 1'b0};
    start();
    for (int i = 7; i >= 0; i--)
      bit_io(a[i], q[i]);
    step(1'b0, 1'b0);
    repeat (n) @(posedge clk);
    step(1'b1, 1'b0);
  endtask : hang
endmodule : smb_host
`default_nettype wire

//--- dv/dual_channel_temp_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmon_cfg.svh"
module dual_channel_temp_monitor_tb_top
  import tmon_pkg::*;
;
  logic    clk_sys;
  logic    resetn;
  logic    scl;
  logic    sda;
  logic    sda_out;
  logic    sda_oe;
  logic    alert_oe;
  logic    ovt_oe;
  sample_t smp;
  int      err_total;
  int      compares;

  tmon_core #(.CONV_CYCLES(3000), .RATE_CYCLES(8000), .TIMEOUT_CYCLES(300)) tmon_core_inst (
    .CLK_SYS(clk_sys), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .LOCAL_SAMPLE(smp.loc), .REMOTE_SAMPLE(smp.rem),
    .REMOTE_JUNCTION_SHORT(smp.rem_short), .REMOTE_JUNCTION_OPEN(smp.rem_open),
    .ALERT_OE(alert_oe), .OVERTEMP_OUT_OE(ovt_oe));

  smb_host smb_host_inst (.clk(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  always #5 clk_sys = ~clk_sys;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic has_d);
    logic ok;
    smb_host_inst.write(cmd, d, has_d, ok);
    check({7'h0, ok}, 8'h01);
  endtask : wr

  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] q;
    logic       ok;
    smb_host_inst.read(`TM_DEV_ADDR, cmd, 1'b1, q, ok);
    check(q, exp);
    check({7'h0, ok}, 8'h01);
  endtask : rd_chk

  task automatic sc_reset();
    logic [7:0] q;
    logic       ok;
    repeat (3100) @(posedge clk_sys);
    smb_host_inst.read(`TM_DEV_ADDR, 8'h00, 1'b0, q, ok);
    check(q, 8'h19);
    check({7'h0, ok}, 8'h01);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h05, 8'h55);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'h5f);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h19, 8'h7d);
    rd_chk(8'h20, 8'h55);
    rd_chk(8'h11, 8'h40);
    rd_chk(8'h10, 8'h80);
    rd_chk(8'h30, 8'h00);
  endtask : sc_reset

  task automatic sc_oneshot();
    wr(8'h03, 8'h40, 1'b1);
    smp.loc <= 11'h155;
    smp.rem <= 11'h1e3;
    wr(8'h0f, 8'h00, 1'b0);
    repeat (3100) @(posedge clk_sys);
    rd_chk(8'h00, 8'h2a);
    rd_chk(8'h01, 8'h3c);
    rd_chk(8'h11, 8'ha0);
    rd_chk(8'h10, 8'h60);
    smp.loc <= 11'h198;
    repeat (9000) @(posedge clk_sys);
    rd_chk(8'h00, 8'h2a);
  endtask : sc_oneshot

  task automatic sc_busy();
    wr(8'h0f, 8'h00, 1'b0);
    rd_chk(8'h02, 8'h80);
    rd_chk(8'h00, 8'h2a);
    repeat (1000) @(posedge clk_sys);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h00, 8'h33);
  endtask : sc_busy

  task automatic sc_abort();
    smp.loc <= 11'h220;
    wr(8'h0f, 8'h00, 1'b0);
    wr(8'h03, 8'h00, 1'b1);
    wr(8'h03, 8'h40, 1'b1);
    repeat (3100) @(posedge clk_sys);
    rd_chk(8'h00, 8'h33);
  endtask : sc_abort

  task automatic sc_alarm();
    wr(8'h05, 8'h44, 1'b1);
    wr(8'h20, 8'h44, 1'b1);
    wr(8'h0f, 8'h00, 1'b0);
    repeat (3100) @(posedge clk_sys);
    check({7'h0, alert_oe}, 8'h01);
    check({7'h0, ovt_oe}, 8'h01);
    smp.loc <= 11'h218;
    wr(8'h0f, 8'h00, 1'b0);
    repeat (3100) @(posedge clk_sys);
    check({7'h0, alert_oe}, 8'h01);
    check({7'h0, ovt_oe}, 8'h00);
    rd_chk(8'h02, 8'h41);
    check({7'h0, alert_oe}, 8'h00);
  endtask : sc_alarm

  task automatic sc_fault();
    logic [7:0] q;
    logic       ok;
    smp.rem_open <= 1'b1;
    wr(8'h0f, 8'h00, 1'b0);
    repeat (3100) @(posedge clk_sys);
    rd_chk(8'h01, 8'hff);
    rd_chk(8'h02, 8'h16);
    smp.rem_open  <= 1'b0;
    smp.rem_short <= 1'b1;
    wr(8'h0f, 8'h00, 1'b0);
    repeat (3100) @(posedge clk_sys);
    rd_chk(8'h01, 8'hff);
    smb_host_inst.read(`TM_ARA_ADDR, 8'h00, 1'b0, q, ok);
    check(q, {`TM_DEV_ADDR, 1'b0});
    check({7'h0, ok}, 8'h01);
    check({7'h0, alert_oe}, 8'h01);
  endtask : sc_fault

  task automatic sc_timeout();
    smb_host_inst.hang(400);
    check({7'h0, sda_oe}, 8'h00);
    rd_chk(8'h20, 8'h44);
  endtask : sc_timeout

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial
  begin
    clk_sys   = 1'b0;
    resetn    = 1'b0;
    err_total = 0;
    compares  = 0;
    smp       = '{loc: 11'h0ca, rem: 11'h0f4, rem_short: 1'b0, rem_open: 1'b0};
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    sc_reset();
    sc_oneshot();
    sc_busy();
    sc_abort();
    sc_alarm();
    sc_fault();
    sc_timeout();
    wrap_up();
  end
endmodule : dual_channel_temp_monitor_tb_top

bind tmon_core tmon_core_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) tmon_core_asserts_inst (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .ALERT_OE(ALERT_OE), .OVERTEMP_OUT_OE(OVERTEMP_OUT_OE));
`default_nettype wire
